// file: hdl/drc_pkg.sv
// Constants, types and register map of the playback range control block
// Function
// R1: The right channel goes through the high-pass filter only while control bit 0 is set.
// R2: The high-pass coefficient is high bits 10:0 joined to the low word, signed 3.24.
// R3: The left energy average coefficient is an 11-bit high part joined to a low word, 3.24.
// R4: The right energy average coefficient is its own 11-bit high part and low word, 3.24.
// R5: The decay coefficient, 11-bit high and 16-bit low, drives the smoother in decay.
// R6: The attack coefficient, 11-bit high and 16-bit low, drives the smoother in attack.
// R7: Energy is compared with a threshold built from two full words, signed 8.24.
// R8: The gain curve slope is an 11-bit high part joined to a low word, signed 3.24.
// R9: The gain curve offset is a 13-bit high part joined to a low word, signed 5.24.
// R10: The gain starts at one when option bit 5 is clear and at zero when it is set.
// R11: Decay turns to attack on a fall above hysteresis, attack to decay on a rise above it.
// R12: Hysteresis code n means 2^(n-20), code 0 acts as code 4, codes 0x14 up mean one.
// R13: Serial 1 slot 0, slot 1 and serial 2 use range control only with bits 15, 13, 11.
// R14: The converter path uses range control only with bit 7; other enable bits are reserved.
// R15: The left channel goes through the high-pass filter only while control bit 1 is set.
// R16: Energies and gain advance once per sample of an enabled path; the filters advance on every valid sample.
// R17: Coefficients use the latest written halves and reserved bits read as zero.
package drc_pkg;
  localparam int NUM_REGS = 19;
  localparam int IDX_CTRL = 0;
  localparam int IDX_HPF_HI = 1;
  localparam int IDX_HPF_LO = 2;
  localparam int IDX_LAVG_HI = 3;
  localparam int IDX_LAVG_LO = 4;
  localparam int IDX_RAVG_HI = 5;
  localparam int IDX_RAVG_LO = 6;
  localparam int IDX_DEC_HI = 7;
  localparam int IDX_DEC_LO = 8;
  localparam int IDX_ATK_HI = 9;
  localparam int IDX_ATK_LO = 10;
  localparam int IDX_THR_HI = 11;
  localparam int IDX_THR_LO = 12;
  localparam int IDX_SLOPE_HI = 13;
  localparam int IDX_SLOPE_LO = 14;
  localparam int IDX_OFS_HI = 15;
  localparam int IDX_OFS_LO = 16;
  localparam int IDX_OPT = 17;
  localparam int IDX_ENA = 18;
  localparam logic [7:0] REG_OFS [NUM_REGS] = '{
    8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'ha8, 8'ha9,
    8'haa, 8'hab, 8'hac, 8'had, 8'hae, 8'haf, 8'hb0, 8'hb1, 8'hb5};
  localparam logic [15:0] REG_MASK [NUM_REGS] = '{
    16'h0007, 16'h07ff, 16'hffff, 16'h07ff, 16'hffff, 16'h07ff, 16'hffff,
    16'h07ff, 16'hffff, 16'h07ff, 16'hffff, 16'hffff, 16'hffff, 16'h07ff,
    16'hffff, 16'h1fff, 16'hffff, 16'h003f, 16'ha880};
  localparam logic [15:0] REG_RESET [NUM_REGS] = '{
    16'h0000, 16'h00ff, 16'hfac1, 16'h0100, 16'h0000, 16'h0100, 16'h0000,
    16'h0100, 16'h0000, 16'h0100, 16'h0000, 16'h04fb, 16'h9ed0, 16'h0780,
    16'h0000, 16'h0100, 16'h0000, 16'h0000, 16'h0000};
  localparam int CTRL_HPF_RIGHT_BIT = 0;
  localparam int CTRL_HPF_LEFT_BIT = 1;
  localparam int CTRL_RANGE_BIT = 2;
  localparam int OPT_GAIN_ZERO_BIT = 5;
  localparam int OPT_HYST_MSB = 4;
  localparam int ENA_BIT [4] = '{15, 13, 11, 7};
  localparam int SAMPLE_W = 24;
  localparam int FRAC_BITS = 24;
  localparam int SQ_SHIFT = 22;
  localparam logic [31:0] UNITY = 32'h0100_0000;
  localparam logic [31:0] GAIN_MAX = 32'h7fff_ffff;
  localparam logic [4:0] HYST_ALIAS_CODE = 5'h04;
  localparam logic [4:0] HYST_SAT_CODE = 5'h14;
  localparam logic [4:0] HYST_SHIFT_BIAS = 5'h04;
  localparam logic [4:0] HYST_SAT_SHIFT = 5'h18;

  typedef enum logic [1:0] {path_serial1_slot0, path_serial1_slot1, path_serial2,
                            path_converter} path_e;
  typedef enum logic {smooth_decay, smooth_attack} smooth_e;
  typedef struct packed {
    logic signed [SAMPLE_W-1:0] left;
    logic signed [SAMPLE_W-1:0] right;
    path_e                      path;
  } sample_s;
endpackage

// file: hdl/dac_drc_parameter_path.sv
// Playback high-pass, energy averaging, gain curve and gain smoothing with its registers
`timescale 1ns/1ps
`default_nettype none
module dac_drc_parameter_path
  import drc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  // Sample stream
  input  wire logic        in_valid,
  input  wire sample_s     in_sample,
  output logic             out_valid,
  output sample_s          out_sample,
  // Gain status
  output logic      [31:0] out_gain,
  output smooth_e          out_smooth
);

  function automatic logic [4:0] reg_index(input logic [7:0] a);
    logic [4:0] r;
    r = 5'(NUM_REGS);
    for (int k = 0; k < NUM_REGS; k++)
      if (a == REG_OFS[k])
        r = 5'(k);
    return r;
  endfunction

  function automatic logic signed [23:0] sat24(input logic signed [63:0] v);
    logic signed [23:0] r;
    r = 24'(v);
    if (v > 64'sh7f_ffff)
      r = 24'sh7f_ffff;
    else if (v < -64'sh80_0000)
      r = -24'sh80_0000;
    return r;
  endfunction

  logic        [15:0]         regs_ff [NUM_REGS];
  logic        [15:0]         reg_rdata_ff;
  logic        [4:0]          acc_idx;
  logic        [15:0]         rd_word;
  logic                       out_valid_ff;
  sample_s                    out_sample_ff;
  logic signed [31:0]         gain_ff;
  smooth_e                    smooth_ff;
  logic signed [SAMPLE_W-1:0] in_ch [2];
  logic signed [SAMPLE_W-1:0] filt [2];
  logic signed [SAMPLE_W-1:0] out_ch [2];
  logic signed [31:0]         energy_ff [2];
  logic signed [26:0]         avg_coef [2];
  logic                       hpf_on [2];

  assign acc_idx = reg_index(reg_addr);
  // R17: unmapped reads zero
  assign rd_word = (acc_idx < 5'(NUM_REGS)) ? regs_ff[acc_idx] : 16'h0000;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++)
    begin : g_reg
      // R17: store masked halves
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
          regs_ff[gi] <= REG_RESET[gi];
        else if (ce && reg_wr && acc_idx == 5'(gi))
          regs_ff[gi] <= reg_wdata & REG_MASK[gi];
      end
    end
  endgenerate

  logic signed [26:0] hpf_coef;
  logic signed [26:0] dec_coef;
  logic signed [26:0] atk_coef;
  logic signed [31:0] thresh;
  logic signed [26:0] slope_k;
  logic signed [28:0] curve_ofs;
  // R2: high-pass coefficient
  assign hpf_coef = {regs_ff[IDX_HPF_HI][10:0], regs_ff[IDX_HPF_LO]};
  // R3: left averaging coefficient
  assign avg_coef[0] = {regs_ff[IDX_LAVG_HI][10:0], regs_ff[IDX_LAVG_LO]};
  // R4: right averaging coefficient
  assign avg_coef[1] = {regs_ff[IDX_RAVG_HI][10:0], regs_ff[IDX_RAVG_LO]};
  // R5: decay coefficient
  assign dec_coef = {regs_ff[IDX_DEC_HI][10:0], regs_ff[IDX_DEC_LO]};
  // R6: attack coefficient
  assign atk_coef = {regs_ff[IDX_ATK_HI][10:0], regs_ff[IDX_ATK_LO]};
  // R7: threshold word pair
  assign thresh = {regs_ff[IDX_THR_HI], regs_ff[IDX_THR_LO]};
  // R8: slope assembly
  assign slope_k = {regs_ff[IDX_SLOPE_HI][10:0], regs_ff[IDX_SLOPE_LO]};
  // R9: offset assembly
  assign curve_ofs = {regs_ff[IDX_OFS_HI][12:0], regs_ff[IDX_OFS_LO]};

  logic range_glb;
  logic path_on;
  logic range_on;
  logic take;
  logic upd;
  assign range_glb = regs_ff[IDX_CTRL][CTRL_RANGE_BIT];
  // R13: serial path enables
  // R14: converter path enable
  assign path_on  = regs_ff[IDX_ENA][ENA_BIT[in_sample.path]];
  assign range_on = range_glb & path_on;
  assign take     = ce & in_valid;
  assign upd      = take & range_on;
  // R15: left filter enable
  assign hpf_on[0] = regs_ff[IDX_CTRL][CTRL_HPF_LEFT_BIT];
  // R1: right filter enable
  assign hpf_on[1] = regs_ff[IDX_CTRL][CTRL_HPF_RIGHT_BIT];
  assign in_ch[0] = in_sample.left;
  assign in_ch[1] = in_sample.right;

  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_ch
      logic signed [SAMPLE_W-1:0] x1_ff;
      logic signed [SAMPLE_W-1:0] y1_ff;
      logic signed [25:0]         hp_sum;
      logic signed [52:0]         hp_prod;
      logic signed [SAMPLE_W-1:0] hp_y;
      logic signed [47:0]         sq;
      logic signed [32:0]         e_err;
      logic signed [59:0]         e_prod;
      logic signed [31:0]         e_nxt;
      logic signed [55:0]         g_prod;
      assign hp_sum  = 26'(y1_ff) + 26'(in_ch[gi]) - 26'(x1_ff);
      assign hp_prod = hp_sum * hpf_coef;
      assign hp_y    = sat24(64'(hp_prod >>> FRAC_BITS));
      assign filt[gi] = hpf_on[gi] ? hp_y : in_ch[gi];
      assign sq      = filt[gi] * filt[gi];
      assign e_err   = 33'(sq >>> SQ_SHIFT) - 33'(energy_ff[gi]);
      assign e_prod  = e_err * avg_coef[gi];
      assign e_nxt   = energy_ff[gi] + 32'(e_prod >>> FRAC_BITS);
      assign g_prod  = filt[gi] * gain_ff;
      assign out_ch[gi] = range_on ? sat24(64'(g_prod >>> FRAC_BITS)) : filt[gi];
      // R16: filter state per sample
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          x1_ff <= '0;
          y1_ff <= '0;
        end
        else if (take)
        begin
          x1_ff <= in_ch[gi];
          y1_ff <= hpf_on[gi] ? hp_y : '0;
        end
      end
      // R16: energy per enabled sample
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
          energy_ff[gi] <= '0;
        else if (ce && !range_glb)
          energy_ff[gi] <= '0;
        else if (upd)
          energy_ff[gi] <= e_nxt;
      end
    end
  endgenerate

  logic signed [31:0] energy_max;
  logic signed [32:0] over;
  logic signed [59:0] k_prod;
  logic signed [60:0] gt_sum;
  logic signed [31:0] gain_tgt;
  logic signed [26:0] smooth_coef;
  logic signed [32:0] g_err;
  logic signed [59:0] s_prod;
  logic signed [31:0] gain_nxt;
  logic signed [32:0] g_rise;
  logic        [4:0]  hyst_code;
  logic        [4:0]  hyst_shift;
  logic signed [32:0] hyst;
  logic               to_attack;
  logic               to_decay;
  smooth_e            smooth_nxt;
  logic signed [31:0] gain_default;

  assign energy_max = (energy_ff[0] > energy_ff[1]) ? energy_ff[0] : energy_ff[1];
  // R7: compare against threshold
  assign over   = 33'(energy_max) - 33'(thresh);
  // R8: slope applied above threshold
  assign k_prod = over * slope_k;
  // R9: offset added to the curve
  assign gt_sum = 61'(curve_ofs) + 61'(k_prod >>> FRAC_BITS);
  assign gain_tgt = (over <= 33'sd0) ? UNITY :
                    (gt_sum < 61'sd0) ? 32'sh0 :
                    (gt_sum > 61'(GAIN_MAX)) ? GAIN_MAX : 32'(gt_sum);
  // R5: decay coefficient in decay
  // R6: attack coefficient in attack
  assign smooth_coef = (smooth_ff == smooth_attack) ? atk_coef : dec_coef;
  assign g_err    = 33'(gain_tgt) - 33'(gain_ff);
  assign s_prod   = g_err * smooth_coef;
  assign gain_nxt = gain_ff + 32'(s_prod >>> FRAC_BITS);
  assign g_rise   = 33'(gain_nxt) - 33'(gain_ff);
  // R12: hysteresis decode
  assign hyst_code  = regs_ff[IDX_OPT][OPT_HYST_MSB:0];
  assign hyst_shift = (hyst_code == 5'h00) ? HYST_ALIAS_CODE + HYST_SHIFT_BIAS :
                      (hyst_code >= HYST_SAT_CODE) ? HYST_SAT_SHIFT :
                      hyst_code + HYST_SHIFT_BIAS;
  assign hyst = 33'sd1 <<< hyst_shift;
  // R11: hysteresis state change
  assign to_attack = (smooth_ff == smooth_decay) && (-g_rise > hyst);
  assign to_decay  = (smooth_ff == smooth_attack) && (g_rise > hyst);
  assign smooth_nxt = to_attack ? smooth_attack : to_decay ? smooth_decay : smooth_ff;
  // R10: default gain option
  assign gain_default = regs_ff[IDX_OPT][OPT_GAIN_ZERO_BIT] ? 32'sh0 : UNITY;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      reg_rdata_ff <= 16'h0000;
    else if (ce && reg_rd)
      reg_rdata_ff <= rd_word;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      out_valid_ff  <= 1'b0;
      out_sample_ff <= '0;
    end
    else if (ce)
    begin
      out_valid_ff <= in_valid;
      if (in_valid)
        out_sample_ff <= '{left: out_ch[0], right: out_ch[1], path: in_sample.path};
    end
  end

  // R16: gain advances per enabled sample
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      gain_ff   <= UNITY;
      smooth_ff <= smooth_decay;
    end
    else if (ce && !range_glb)
    begin
      gain_ff   <= gain_default;
      smooth_ff <= smooth_decay;
    end
    else if (upd)
    begin
      gain_ff   <= gain_nxt;
      smooth_ff <= smooth_nxt;
    end
  end

  assign reg_rdata  = reg_rdata_ff;
  assign out_valid  = out_valid_ff;
  assign out_sample = out_sample_ff;
  assign out_gain   = gain_ff;
  assign out_smooth = smooth_ff;

  out_follows_a: assert property (@(posedge mclk) disable iff (rst) // R16
    ce |=> (out_valid == $past(in_valid)))
    else $error("output valid does not follow input valid");
  gain_default_a: assert property (@(posedge mclk) disable iff (rst) // R10
    (ce && !range_glb) |=> (gain_ff == $past(gain_default)))
    else $error("gain not reloaded with default");
  left_bypass_a: assert property (@(posedge mclk) disable iff (rst) // R15
    (take && !range_on && !hpf_on[0]) |=> (out_sample.left == $past(in_sample.left)))
    else $error("left sample altered while bypassed");
  right_bypass_a: assert property (@(posedge mclk) disable iff (rst) // R1
    (take && !range_on && !hpf_on[1]) |=> (out_sample.right == $past(in_sample.right)))
    else $error("right sample altered while bypassed");
  hyst_ends_a: assert property (@(posedge mclk) disable iff (rst) // R12
    ((hyst_code == 5'h00) |-> (hyst == 33'sh100)) and
    ((hyst_code >= HYST_SAT_CODE) |-> (hyst == 33'(UNITY))))
    else $error("hysteresis decode wrong at range ends");
  decay_attack_a: assert property (@(posedge mclk) disable iff (rst) // R11
    (upd && range_glb && smooth_ff == smooth_decay && (gain_ff - gain_nxt > hyst))
    |=> (smooth_ff == smooth_attack))
    else $error("smoother missed decay to attack");
  attack_decay_a: assert property (@(posedge mclk) disable iff (rst) // R11
    (upd && smooth_ff == smooth_attack && (gain_nxt - gain_ff > hyst))
    |=> (smooth_ff == smooth_decay))
    else $error("smoother missed attack to decay");
  gain_hold_a: assert property (@(posedge mclk) disable iff (rst) // R16
    (ce && range_glb && !upd) |=> $stable(gain_ff) && $stable(smooth_ff))
    else $error("gain moved without an enabled sample");
  unmapped_zero_a: assert property (@(posedge mclk) disable iff (rst) // R17
    (ce && reg_rd && acc_idx == 5'(NUM_REGS)) |=> (reg_rdata == 16'h0000))
    else $error("unmapped read not zero");
endmodule // dac_drc_parameter_path
`default_nettype wire

// file: verif/sample_source.sv
// Far-side sample source standing in for the serial and converter playback paths
`timescale 1ns/1ps
`default_nettype none
module sample_source
  import drc_pkg::*;
(
  // Clock
  input  wire logic mclk,
  // Sample stream toward the block
  output var logic    in_valid,
  output var sample_s in_sample
);
  initial
  begin
    in_valid  = 1'b0;
    in_sample = '0;
  end

  // One sample per call; when idle the bus shows the inverse, never stale data
  task automatic send(input sample_s s);
    @(posedge mclk);
    in_valid  <= 1'b1;
    in_sample <= s;
    @(posedge mclk);
    in_valid  <= 1'b0;
    in_sample <= ~s;
  endtask
endmodule // sample_source
`default_nettype wire

// file: verif/test_dac_drc_parameter_path.sv
// Self-checking bench for the playback range control block
`timescale 1ns/1ps
`default_nettype none
module test_dac_drc_parameter_path;
  import drc_pkg::*;
  localparam int LIMIT = 20000;
  logic        mclk;
  logic        rst;
  logic        ce;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        in_valid;
  sample_s     in_sample;
  logic        out_valid;
  sample_s     out_sample;
  logic [31:0] out_gain;
  smooth_e     out_smooth;
  int          bad_count;
  int          checks_done;
  int          cycles;
  logic [15:0] rv;
  longint      hx [2];
  longint      hy [2];
  logic [15:0] codes [4] = '{16'h0000, 16'h0013, 16'h0014, 16'h001f};
  smooth_e     sm_exp [4] = '{smooth_attack, smooth_attack, smooth_decay, smooth_decay};

  initial mclk = 1'b0;
  always #20 mclk = ~mclk;

  dac_drc_parameter_path u_dac_drc_parameter_path (
    .mclk(mclk), .rst(rst), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .in_valid(in_valid), .in_sample(in_sample), .out_valid(out_valid),
    .out_sample(out_sample), .out_gain(out_gain), .out_smooth(out_smooth));

  sample_source u_src (.mclk(mclk), .in_valid(in_valid), .in_sample(in_sample));

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      bad_count = bad_count + 1;
      results();
    end
  end

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      bad_count = bad_count + 1;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
  endtask

  function automatic sample_s mk(input logic [23:0] l, input logic [23:0] r, input int p);
    sample_s s;
    s.left  = l;
    s.right = r;
    s.path  = path_e'(p);
    return s;
  endfunction

  task automatic send_chk(input sample_s s, input sample_s e, input logic [31:0] g,
                          input smooth_e sm);
    u_src.send(s);
    @(negedge mclk);
    chk("out_valid", 64'h1, 64'(out_valid));
    chk("out_sample", 64'(e), 64'(out_sample));
    chk("out_gain", 64'(g), 64'(out_gain));
    chk("out_smooth", 64'(sm), 64'(out_smooth));
  endtask

  // Half-gain high-pass model; a bypassed channel restarts its output history at zero
  task automatic hpf(input logic [15:0] ctrl, input logic [23:0] x);
    longint y [2];
    wr(8'ha0, ctrl);
    for (int c = 0; c < 2; c++)
    begin
      y[c]  = ((hy[c] + longint'(x) - hx[c]) * 64'sh80_0000) >>> 24;
      hx[c] = longint'(x);
      hy[c] = ctrl[1 - c] ? y[c] : 0;
    end
    send_chk(mk(x, x, 3), mk(ctrl[1] ? y[0][23:0] : x, ctrl[0] ? y[1][23:0] : x, 3),
             UNITY, smooth_decay);
  endtask

  // Target forced to zero; only the enabled path may pull the gain down
  task automatic drop(input int p, input logic [15:0] code, input smooth_e sm);
    sample_s s;
    wr(8'hb1, code);
    wr(8'ha0, 16'h0000);
    wr(8'ha0, 16'h0004);
    wr(8'hb5, 16'(16'h1 << ENA_BIT[p]));
    s = mk(24'h100000, 24'h080000, (p + 1) % 4);
    send_chk(s, s, UNITY, smooth_decay);
    s.path = path_e'(p);
    // First enabled sample only builds energy; the target still sees zero energy
    send_chk(s, s, UNITY, smooth_decay);
    send_chk(s, s, 32'h0, sm);
    send_chk(s, mk(24'h0, 24'h0, p), 32'h0, sm);
  endtask

  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    bad_count = 0;
    checks_done = 0;
    cycles = 0;
    hx = '{0, 0};
    hy = '{0, 0};
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < NUM_REGS; i++)
    begin
      rd(REG_OFS[i], rv);
      chk("reset value", 64'(REG_RESET[i]), 64'(rv));
    end
    for (int i = 0; i < NUM_REGS; i++)
    begin
      wr(REG_OFS[i], 16'hffff);
      rd(REG_OFS[i], rv);
      chk("writable bits", 64'(REG_MASK[i]), 64'(rv));
      wr(REG_OFS[i], REG_RESET[i]);
    end
    wr(8'hb2, 16'hffff);
    rd(8'hb2, rv);
    chk("unmapped read", 64'h0, 64'(rv));
    wr(8'ha1, 16'h0080);
    wr(8'ha2, 16'h0000);
    hpf(16'h0001, 24'd1000);
    hpf(16'h0002, 24'd1000);
    hpf(16'h0003, 24'd3000);
    wr(8'ha0, 16'h0000);
    @(posedge mclk);
    ce <= 1'b0;
    u_src.send(mk(24'h5, 24'h5, 3));
    @(negedge mclk);
    chk("frozen out_valid", 64'h0, 64'(out_valid));
    @(posedge mclk);
    ce <= 1'b1;
    wr(8'hb1, 16'h0020);
    repeat (2) @(negedge mclk);
    chk("default gain zero", 64'h0, 64'(out_gain));
    wr(8'hb1, 16'h0000);
    repeat (2) @(negedge mclk);
    chk("default gain one", 64'(UNITY), 64'(out_gain));
    wr(8'hab, 16'h0000);
    wr(8'hac, 16'h0000);
    wr(8'had, 16'h0000);
    wr(8'haf, 16'h0000);
    for (int p = 0; p < 4; p++)
      drop(p, codes[p], sm_exp[p]);
    drop(3, 16'h0013, smooth_attack);
    wr(8'haf, 16'h0100);
    send_chk(mk(24'h100000, 24'h080000, 3), mk(24'h0, 24'h0, 3), UNITY, smooth_decay);
    wr(8'hab, 16'h04fb);
    wr(8'hac, 16'h9ed0);
    wr(8'haf, 16'h0000);
    wr(8'ha0, 16'h0000);
    wr(8'ha0, 16'h0004);
    // Second sample meets built-up energy that stays below the threshold
    repeat (2)
      send_chk(mk(24'h100000, 24'h080000, 3), mk(24'h100000, 24'h080000, 3), UNITY,
               smooth_decay);
    results();
  end
endmodule // test_dac_drc_parameter_path
`default_nettype wire
